// *** hw/gpp_port.sv ***
/*
 * General-purpose port: AXI4-Lite register slave plus registered pin drive.
 * Assumes pin and peripheral inputs are synchronous to i_clock.
 */
// Operation
// [RQ1] Data register writes the driven pin values; reads return pin levels.
// [RQ2] Drive-enable bit per pin switches that pin's output driver.
// [RQ3] Input buffer has its own enable bit, independent of the driver.
// [RQ4] After reset all input enables read zero, no input buffer active.
// [RQ5] Alternate-select bit of one connects the pin to its peripheral.
// [RQ6] Open-drain bit of one drives only low, driver off for high.
// [RQ7] Pull-up enable bit switches that pin's pull-up resistor.
// [RQ8] Pull-down enable bit switches that pin's pull-down resistor.
// [RQ9] Reset leaves every pin general purpose, input, output, pull-up off.
// [RQ10] Software clears alternate-select bits for general-purpose use.
// [RQ11] Control registers reset to zero; disabled inputs read as zero.
`timescale 1ns/1ns
`default_nettype none

module gpp_port #(
    parameter int unsigned PINS = 8
) (
    // Clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_reset_n,
    // AXI4-Lite write address and data
    input  wire logic [gpp_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_awvalid,
    output var  logic                       o_awready,
    input  wire logic [gpp_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [gpp_pkg::STRB_W-1:0] i_wstrb,
    input  wire logic                       i_wvalid,
    output var  logic                       o_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                 o_bresp,
    output var  logic                       o_bvalid,
    input  wire logic                       i_bready,
    // AXI4-Lite read
    input  wire logic [gpp_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                       i_arvalid,
    output var  logic                       o_arready,
    output var  logic [gpp_pkg::DATA_W-1:0] o_rdata,
    output var  logic [1:0]                 o_rresp,
    output var  logic                       o_rvalid,
    input  wire logic                       i_rready,
    // Pins
    input  wire logic [PINS-1:0]            i_pin_in,
    output var  logic [PINS-1:0]            o_pin_out,
    output var  logic [PINS-1:0]            o_pin_oe,
    output var  logic [PINS-1:0]            o_pullup_en,
    output var  logic [PINS-1:0]            o_pulldown_en,
    // Peripheral functions
    input  wire logic [PINS-1:0]            i_alt_out,
    input  wire logic [PINS-1:0]            i_alt_oe,
    output var  logic [PINS-1:0]            o_alt_in
);

    if (PINS < 1 || PINS > gpp_pkg::MAX_PINS) begin : g_bad_pins
        $error("gpp_port: PINS must lie between 1 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic gpp_pkg::gpp_reg_e decode(input logic [gpp_pkg::ADDR_W-1:0] addr);
        case (addr)
            gpp_pkg::OFS_PIN_VALUE:  decode = gpp_pkg::REG_PIN_VALUE;
            gpp_pkg::OFS_DRIVE_EN:   decode = gpp_pkg::REG_DRIVE_EN;
            gpp_pkg::OFS_ALT_SELECT: decode = gpp_pkg::REG_ALT_SELECT;
            gpp_pkg::OFS_OPEN_DRAIN: decode = gpp_pkg::REG_OPEN_DRAIN;
            gpp_pkg::OFS_PULLUP_EN:  decode = gpp_pkg::REG_PULLUP_EN;
            gpp_pkg::OFS_PULLDN_EN:  decode = gpp_pkg::REG_PULLDN_EN;
            gpp_pkg::OFS_INPUT_EN:   decode = gpp_pkg::REG_INPUT_EN;
            default:                 decode = gpp_pkg::REG_NONE;
        endcase
    endfunction

    // Byte-lane merge of a write into an existing register
    function automatic logic [PINS-1:0] merge(input logic [PINS-1:0]            old,
                                              input logic [gpp_pkg::DATA_W-1:0] wd,
                                              input logic [gpp_pkg::STRB_W-1:0] st);
        logic [gpp_pkg::DATA_W-1:0] wide;
        wide = gpp_pkg::DATA_W'(old);
        for (int b = 0; b < int'(gpp_pkg::STRB_W); b++) begin
            if (st[b]) begin
                wide[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge = wide[PINS-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file and bus state

    logic [PINS-1:0]            pin_value_q,  pin_value_d;
    logic [PINS-1:0]            drive_en_q,   drive_en_d;
    logic [PINS-1:0]            alt_sel_q,    alt_sel_d;
    logic [PINS-1:0]            open_drn_q,   open_drn_d;
    logic [PINS-1:0]            pullup_q,     pullup_d;
    logic [PINS-1:0]            pulldn_q,     pulldn_d;
    logic [PINS-1:0]            input_en_q,   input_en_d;
    logic                       aw_have_q,    aw_have_d;
    logic                       w_have_q,     w_have_d;
    logic [gpp_pkg::ADDR_W-1:0] waddr_q,      waddr_d;
    logic [gpp_pkg::DATA_W-1:0] wdata_q,      wdata_d;
    logic [gpp_pkg::STRB_W-1:0] wstrb_q,      wstrb_d;
    logic                       awready_q,    awready_d;
    logic                       wready_q,     wready_d;
    logic                       bvalid_q,     bvalid_d;
    logic [1:0]                 bresp_q,      bresp_d;
    logic                       arready_q,    arready_d;
    logic                       rvalid_q,     rvalid_d;
    logic [1:0]                 rresp_q,      rresp_d;
    logic [gpp_pkg::DATA_W-1:0] rdata_q,      rdata_d;
    logic [PINS-1:0]            pin_out_q,    pin_oe_q,   alt_in_q;

    gpp_pad_if #(.PINS(PINS)) pads ();

    gpp_pin_mux u_mux (
        .pads (pads.mux)
    );

    assign pads.data       = pin_value_q;
    assign pads.drive_en   = drive_en_q;
    assign pads.input_en   = input_en_q;
    assign pads.alt_sel    = alt_sel_q;
    assign pads.open_drain = open_drn_q;
    assign pads.alt_out    = i_alt_out;
    assign pads.alt_oe     = i_alt_oe;
    assign pads.pin_in     = i_pin_in;

    always_comb begin
        gpp_pkg::gpp_reg_e wsel;
        gpp_pkg::gpp_reg_e rsel;
        wsel        = decode(waddr_q);
        rsel        = decode(i_araddr);
        pin_value_d = pin_value_q;
        drive_en_d  = drive_en_q;
        alt_sel_d   = alt_sel_q;
        open_drn_d  = open_drn_q;
        pullup_d    = pullup_q;
        pulldn_d    = pulldn_q;
        input_en_d  = input_en_q;
        aw_have_d   = aw_have_q;
        w_have_d    = w_have_q;
        waddr_d     = waddr_q;
        wdata_d     = wdata_q;
        wstrb_d     = wstrb_q;
        awready_d   = awready_q;
        wready_d    = wready_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        arready_d   = arready_q;
        rvalid_d    = rvalid_q;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;

        // Address and data are taken in either order
        if (i_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awready_d = 1'b0;
            waddr_d   = i_awaddr;
        end
        if (i_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wready_d = 1'b0;
            wdata_d  = i_wdata;
            wstrb_d  = i_wstrb;
        end
        if (aw_have_q && w_have_q) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = gpp_pkg::RESP_OKAY;
            case (wsel)
                gpp_pkg::REG_PIN_VALUE:  pin_value_d = merge(pin_value_q, wdata_q, wstrb_q); // [RQ1]
                gpp_pkg::REG_DRIVE_EN:   drive_en_d  = merge(drive_en_q, wdata_q, wstrb_q);  // [RQ2]
                gpp_pkg::REG_ALT_SELECT: alt_sel_d   = merge(alt_sel_q, wdata_q, wstrb_q);   // [RQ5]
                gpp_pkg::REG_OPEN_DRAIN: open_drn_d  = merge(open_drn_q, wdata_q, wstrb_q);  // [RQ6]
                gpp_pkg::REG_PULLUP_EN:  pullup_d    = merge(pullup_q, wdata_q, wstrb_q);    // [RQ7]
                gpp_pkg::REG_PULLDN_EN:  pulldn_d    = merge(pulldn_q, wdata_q, wstrb_q);    // [RQ8]
                gpp_pkg::REG_INPUT_EN:   input_en_d  = merge(input_en_q, wdata_q, wstrb_q);  // [RQ3]
                default:                 bresp_d     = gpp_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid_q && i_bready) begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end

        // Read: one outstanding, answered the cycle after the address
        if (i_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = gpp_pkg::RESP_OKAY;
            rdata_d   = '0;
            case (rsel)
                // Pin level, zero where the input buffer is off
                gpp_pkg::REG_PIN_VALUE:  rdata_d[PINS-1:0] = pads.pin_in_gated;    // [RQ1] [RQ11]
                gpp_pkg::REG_DRIVE_EN:   rdata_d[PINS-1:0] = drive_en_q;
                gpp_pkg::REG_ALT_SELECT: rdata_d[PINS-1:0] = alt_sel_q;
                gpp_pkg::REG_OPEN_DRAIN: rdata_d[PINS-1:0] = open_drn_q;
                gpp_pkg::REG_PULLUP_EN:  rdata_d[PINS-1:0] = pullup_q;
                gpp_pkg::REG_PULLDN_EN:  rdata_d[PINS-1:0] = pulldn_q;
                gpp_pkg::REG_INPUT_EN:   rdata_d[PINS-1:0] = input_en_q;
                default:                 rresp_d = gpp_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_q && i_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_value_q <= gpp_pkg::RST_PIN_VALUE[PINS-1:0];
            drive_en_q  <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ9] [RQ11]
            alt_sel_q   <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ9]
            open_drn_q  <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ11]
            pullup_q    <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ9]
            pulldn_q    <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ11]
            input_en_q  <= gpp_pkg::RST_CONTROL[PINS-1:0];                         // [RQ4]
            aw_have_q   <= 1'b0;
            w_have_q    <= 1'b0;
            waddr_q     <= '0;
            wdata_q     <= '0;
            wstrb_q     <= '0;
            awready_q   <= 1'b1;
            wready_q    <= 1'b1;
            bvalid_q    <= 1'b0;
            bresp_q     <= gpp_pkg::RESP_OKAY;
            arready_q   <= 1'b1;
            rvalid_q    <= 1'b0;
            rresp_q     <= gpp_pkg::RESP_OKAY;
            rdata_q     <= '0;
            pin_out_q   <= '0;
            pin_oe_q    <= '0;
            alt_in_q    <= '0;
        end else begin
            pin_value_q <= pin_value_d;
            drive_en_q  <= drive_en_d;
            alt_sel_q   <= alt_sel_d;
            open_drn_q  <= open_drn_d;
            pullup_q    <= pullup_d;
            pulldn_q    <= pulldn_d;
            input_en_q  <= input_en_d;
            aw_have_q   <= aw_have_d;
            w_have_q    <= w_have_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            awready_q   <= awready_d;
            wready_q    <= wready_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            arready_q   <= arready_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            // Pin drive lags the registers by one cycle; outputs stay glitch free
            pin_out_q   <= pads.pin_out;                                           // [RQ2] [RQ6]
            pin_oe_q    <= pads.pin_oe;                                            // [RQ2] [RQ5]
            alt_in_q    <= pads.pin_in_gated;                                      // [RQ3]
        end
    end

    assign o_awready     = awready_q;
    assign o_wready      = wready_q;
    assign o_bvalid      = bvalid_q;
    assign o_bresp       = bresp_q;
    assign o_arready     = arready_q;
    assign o_rvalid      = rvalid_q;
    assign o_rresp       = rresp_q;
    assign o_rdata       = rdata_q;
    assign o_pin_out     = pin_out_q;
    assign o_pin_oe      = pin_oe_q;
    assign o_pullup_en   = pullup_q;                                               // [RQ7]
    assign o_pulldown_en = pulldn_q;                                               // [RQ8]
    assign o_alt_in      = alt_in_q;

endmodule

`default_nettype wire

// *** common/gpp_pkg.sv ***
/*
 * Constants of the general-purpose port pin control block: register
 * offsets, reset values and bus response codes.
 * Assumes a 32-bit register bus, one aligned word per register.
 */
`default_nettype none

package gpp_pkg;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned STRB_W      = DATA_W / 8;
    localparam int unsigned MAX_PINS    = 32;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_VALUE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DRIVE_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ALT_SELECT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_EN  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PULLDN_EN  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INPUT_EN   = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [MAX_PINS-1:0] RST_PIN_VALUE = 32'h0000_0000;
    localparam logic [MAX_PINS-1:0] RST_CONTROL   = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register selected by a byte address
    typedef enum logic [2:0] {
        REG_PIN_VALUE  = 3'h0,
        REG_DRIVE_EN   = 3'h1,
        REG_ALT_SELECT = 3'h2,
        REG_OPEN_DRAIN = 3'h3,
        REG_PULLUP_EN  = 3'h4,
        REG_PULLDN_EN  = 3'h5,
        REG_INPUT_EN   = 3'h6,
        REG_NONE       = 3'h7
    } gpp_reg_e;

endpackage

`default_nettype wire

// *** common/gpp_pad_if.sv ***
/*
 * Carrier between the port register file and its pin multiplexer.
 * Assumes both ends share one clock; the multiplexer is combinational.
 */
`timescale 1ns/1ns
`default_nettype none

interface gpp_pad_if #(
    parameter int unsigned PINS = 8
);
    logic [PINS-1:0] data;
    logic [PINS-1:0] drive_en;
    logic [PINS-1:0] input_en;
    logic [PINS-1:0] alt_sel;
    logic [PINS-1:0] open_drain;
    logic [PINS-1:0] alt_out;
    logic [PINS-1:0] alt_oe;
    logic [PINS-1:0] pin_in;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe;
    logic [PINS-1:0] pin_in_gated;

    modport ctl (
        output data, drive_en, input_en, alt_sel, open_drain, alt_out, alt_oe, pin_in,
        input  pin_out, pin_oe, pin_in_gated
    );
    modport mux (
        input  data, drive_en, input_en, alt_sel, open_drain, alt_out, alt_oe, pin_in,
        output pin_out, pin_oe, pin_in_gated
    );
endinterface

`default_nettype wire

// *** hw/gpp_pin_mux.sv ***
/*
 * Per-pin output and input steering for one port.
 * Assumes the enclosing block registers every result before a pin.
 */
`timescale 1ns/1ns
`default_nettype none

module gpp_pin_mux (
    // Port control and pin levels
    gpp_pad_if.mux pads
);
    logic [$bits(pads.data)-1:0] drv_val;
    logic [$bits(pads.data)-1:0] drv_en;

    always_comb begin
        // Alternate function takes the pin over from the port logic
        drv_val = (pads.alt_sel & pads.alt_out) | (~pads.alt_sel & pads.data);     // [RQ5]
        drv_en  = (pads.alt_sel & pads.alt_oe) | (~pads.alt_sel & pads.drive_en);  // [RQ2]
        // Pseudo open drain: only a low level is driven, high floats
        pads.pin_out = drv_val & ~pads.open_drain;                                 // [RQ6]
        pads.pin_oe  = drv_en & ~(pads.open_drain & drv_val);                      // [RQ6]
        // Input buffer is independent of the driver
        pads.pin_in_gated = pads.pin_in & pads.input_en;                           // [RQ3]
    end

endmodule

`default_nettype wire

// *** bench/gpp_pad_model.sv ***
/*
 * Pad model: resolves each pin's level from the port's drive, pulls and
 * an outside source. Assumes outside levels arrive synchronous to the clock.
 */
`timescale 1ns/1ns
`default_nettype none

module gpp_pad_model #(
    parameter int unsigned PINS = 8
) (
    // Port side
    input  wire logic [PINS-1:0] i_out,
    input  wire logic [PINS-1:0] i_oe,
    input  wire logic [PINS-1:0] i_pu,
    input  wire logic [PINS-1:0] i_pd,
    // Outside source for floating pins
    input  wire logic [PINS-1:0] i_float,
    output var  logic [PINS-1:0] o_level
);
    // A pin nobody drives or pulls follows a pattern that changes every cycle
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (i_oe[i])
                o_level[i] = i_out[i];
            else if (i_pu[i])
                o_level[i] = 1'b1;
            else if (i_pd[i])
                o_level[i] = 1'b0;
            else
                o_level[i] = i_float[i];
        end
    end
endmodule

`default_nettype wire

// *** bench/gpp_port_assertions.sv ***
/*
 * Port checker: bus answer timing and pin output relations.
 * Assumes it is bound to the port top and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none

module gpp_port_checker #(
    parameter int unsigned PINS = 8
) (
    input wire logic                       i_clock,
    input wire logic                       i_reset_n,
    input wire logic                       i_awvalid,
    input wire logic                       o_awready,
    input wire logic                       i_wvalid,
    input wire logic                       o_wready,
    input wire logic                       o_bvalid,
    input wire logic                       i_bready,
    input wire logic                       i_arvalid,
    input wire logic                       o_arready,
    input wire logic [gpp_pkg::DATA_W-1:0] o_rdata,
    input wire logic [1:0]                 o_rresp,
    input wire logic                       o_rvalid,
    input wire logic                       i_rready,
    input wire logic [PINS-1:0]            i_pin_in,
    input wire logic [PINS-1:0]            o_pin_out,
    input wire logic [PINS-1:0]            o_pin_oe,
    input wire logic [PINS-1:0]            o_pullup_en,
    input wire logic [PINS-1:0]            o_pulldown_en,
    input wire logic [PINS-1:0]            o_alt_in
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    chk_pins_reset: assert property (
        $rose(i_reset_n) |-> (o_pin_oe | o_pin_out | o_pullup_en | o_pulldown_en) == '0)
        else $error("pin outputs not idle after reset");
    chk_write_answer: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("write response late");
    chk_write_hold: assert property (
        o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    chk_read_answer: assert property (
        i_arvalid && o_arready |=> o_rvalid)
        else $error("read data late");
    chk_read_hold: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    chk_read_busy: assert property (
        o_rvalid |-> !o_arready)
        else $error("read address taken while busy");
    chk_rdata_width: assert property (
        o_rvalid |-> (o_rdata >> PINS) == '0)
        else $error("read data above pin count");
    chk_input_gated: assert property (
        (o_alt_in & ~$past(i_pin_in)) == '0)
        else $error("peripheral input not from pin");
    chk_pullup_cause: assert property (
        $changed(o_pullup_en) |-> o_bvalid)
        else $error("pull-up changed without write");
    chk_pulldn_cause: assert property (
        $changed(o_pulldown_en) |-> o_bvalid)
        else $error("pull-down changed without write");

    cover property (o_rvalid && o_rresp == 2'h2);
    cover property (o_bvalid && !i_bready);
    cover property (o_alt_in != '0);
endmodule

bind gpp_port gpp_port_checker #(.PINS(PINS)) u_gpp_port_checker (.*);

`default_nettype wire

// *** bench/tb_general_purpose_port_pin_control.sv ***
/*
 * Self-checking bench of the port: random rounds of pin setups plus reset,
 * unmapped and strobe corners. Assumes pad model and bound checker.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module tb_general_purpose_port_pin_control;
    logic i_clock = 1'b0, i_reset_n = 1'b0;
    logic [7:0] i_awaddr, i_araddr, i_pin_in, o_pin_out, o_pin_oe, o_pullup_en;
    logic [7:0] o_pulldown_en, i_alt_out, i_alt_oe, o_alt_in, float_q;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, r;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic i_arvalid, o_arready, o_rvalid, i_rready;
    int errors = 0, comparisons = 0, seed = 94;
    logic [7:0] ofs [7] = '{gpp_pkg::OFS_PIN_VALUE, gpp_pkg::OFS_DRIVE_EN,
        gpp_pkg::OFS_ALT_SELECT, gpp_pkg::OFS_OPEN_DRAIN, gpp_pkg::OFS_PULLUP_EN,
        gpp_pkg::OFS_PULLDN_EN, gpp_pkg::OFS_INPUT_EN};
    logic [31:0] q;

    always #50 i_clock = ~i_clock;
    always @(posedge i_clock) float_q <= 8'($random(seed));

    gpp_port #(.PINS(8)) u_gpp_port (.*);
    gpp_pad_model #(.PINS(8)) u_gpp_pad_model (.i_out(o_pin_out), .i_oe(o_pin_oe),
        .i_pu(o_pullup_en), .i_pd(o_pulldown_en), .i_float(float_q), .o_level(i_pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Bus master; ready raised after a random stall to exercise holding
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] rs);
        int k;
        k = $unsigned($random(seed)) % 3;
        @(posedge i_clock);
        i_awaddr <= a; i_awvalid <= 1'b1; i_wdata <= d; i_wstrb <= s; i_wvalid <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (i_bready && o_bvalid) begin
                rs = o_bresp;
                i_bready <= 1'b0;
                break;
            end
            if (k > 0) k--; else i_bready <= 1'b1;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int k;
        k = $unsigned($random(seed)) % 3;
        @(posedge i_clock);
        i_araddr <= a; i_arvalid <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (i_rready && o_rvalid) begin
                d = o_rdata; rs = o_rresp;
                i_rready <= 1'b0;
                break;
            end
            if (k > 0) k--; else i_rready <= 1'b1;
        end
    endtask

    // Pin drive as {value, enable}; open drain never drives high
    function automatic logic [15:0] drive_exp(input logic [7:0] d, e, a, od, po, pe);
        logic [7:0] v, en;
        v = (a & po) | (~a & d);
        en = (a & pe) | (~a & e);
        return {v & ~od, en & ~(od & v)};
    endfunction

    task automatic round();
        logic [7:0] v [7];
        logic [7:0] po, pe, oe, lvl;
        logic [15:0] x;
        foreach (v[i]) v[i] = 8'($random(seed));
        po = 8'($random(seed));
        pe = 8'($random(seed));
        v[3] = v[3] & ~v[2];
        v[5] = v[5] & ~v[4];
        @(posedge i_clock);
        i_alt_out <= po; i_alt_oe <= pe;
        x = drive_exp(v[0], v[1], v[2], v[3], po, pe);
        oe = x[7:0];
        lvl = (oe & x[15:8]) | (~oe & v[4]);
        v[6] = v[6] & (oe | v[4] | v[5]);
        for (int i = 0; i < 7; i++) wr(ofs[i], {24'h0, v[i]}, 4'hf, r);
        repeat (3) @(posedge i_clock);
        `CHK("pin_out", x[15:8], o_pin_out)
        `CHK("pin_oe", oe, o_pin_oe)
        `CHK("pullup", v[4], o_pullup_en)
        `CHK("pulldown", v[5], o_pulldown_en)
        `CHK("alt_in", v[6] & lvl, o_alt_in)
        rd(ofs[0], q, r);
        `CHK("pin_read", {24'h0, v[6] & lvl}, q)
        for (int i = 1; i < 7; i++) begin
            rd(ofs[i], q, r);
            `CHK("readback", {24'h0, v[i]}, q)
        end
        wr(gpp_pkg::OFS_ALT_SELECT, 32'h0, 4'hf, r);
        repeat (3) @(posedge i_clock);
        x = drive_exp(v[0], v[1], 8'h0, v[3], po, pe);
        `CHK("gp_out", x[15:8], o_pin_out)
        $display("test round done");
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge i_clock);
        errors++;
        conclude();
    end

    initial begin
        {i_awaddr, i_araddr, i_wdata, i_wstrb, i_alt_out, i_alt_oe} = '0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], q, r);
            `CHK("reset_value", 32'h0, q)
            `CHK("reset_resp", gpp_pkg::RESP_OKAY, r)
        end
        $display("test reset done");
        foreach (ofs[i]) begin
            wr(8'h1c + 8'(i * 36), 32'hffff_ffff, 4'hf, r);
            `CHK("bad_bresp", gpp_pkg::RESP_SLVERR, r)
            rd(8'h1c + 8'(i * 36), q, r);
            `CHK("bad_rresp", gpp_pkg::RESP_SLVERR, r)
            `CHK("bad_rdata", 32'h0, q)
        end
        wr(gpp_pkg::OFS_DRIVE_EN, 32'hff, 4'h0, r);
        rd(gpp_pkg::OFS_DRIVE_EN, q, r);
        `CHK("no_strobe", 32'h0, q)
        $display("test corners done");
        repeat (8) round();
        conclude();
    end
endmodule

`default_nettype wire
